// ---- isc_map.svh ----
/*
 * Register map, field positions, reset values and bus timing for the
 * two-wire control port of the clock and data recovery receiver.
 * Assumes it is included by the package and the design files by bare name.
 */
// Notes on behaviour
// - slave address is one, select pin, five zeros
// - first byte lsb one reads, zero writes
// - transfer opens with start; slave then takes address
// - eight bits per byte, msb first
// - matching address acknowledged low on ninth pulse
// - mismatch releases bus, waits for next start
// - second byte is starting subaddress of eight
// - subaddress advances after every data byte
// - master closes every transfer with a stop
// - start or stop anywhere; stop forces idle
// - one start or stop per clock high
// - invalid subaddress gets no acknowledge, then idle
// - reads past last register repeat last register
// - output config bit 2 inverts signal absent output
// - action bit 5 one then zero restarts acquisition
// - reference mode bit 0 enables lock to reference
// - reference mode bit 1 enables rate measurement
// - software never sets both reference enables together
// - data rate over 2^ratio equals ref over 2^range
// - range bits 7:6 select 19.44 to 155.52 MHz
// - software programs ratio bits 5:2 to 0101
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

// slave address parts
`define ISC_ADDR_TOP 1'b1
`define ISC_ADDR_LOW5 5'h00

// subaddresses
`define ISC_SUB_REFMODE 3'h0
`define ISC_SUB_ACTION 3'h1
`define ISC_SUB_OUTCFG 3'h2
`define ISC_SUB_STATUS 3'h3
`define ISC_SUB_LAST 3'h7
`define ISC_SUB_LIMIT 8'h08

// field positions
`define ISC_REF_LOCK_BIT 0
`define ISC_REF_MEAS_BIT 1
`define ISC_RATIO_LSB 2
`define ISC_RATIO_MSB 5
`define ISC_RANGE_LSB 6
`define ISC_RANGE_MSB 7
`define ISC_ACQ_BIT 5
`define ISC_LOSPOL_BIT 2

// reset values
`define ISC_REFMODE_RST 8'h00
`define ISC_ACTION_RST 8'h00
`define ISC_OUTCFG_RST 8'h00

// byte framing and bus timing
`define ISC_BYTE_BITS 4'h8
`define ISC_CLK_NS 40
`define ISC_SCL_PERIOD_NS 10000
`define ISC_QTR_CYCLES ((`ISC_SCL_PERIOD_NS / 4) / `ISC_CLK_NS)

`endif

// ---- isc_pkg.sv ----
/*
 * Types shared by both ends of the two-wire control port.
 * Assumes isc_map.svh is on the include path.
 */
`default_nettype none
`include "isc_map.svh"

package isc_pkg;

    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_ADDR = 3'b001,
        DS_SUB = 3'b010,
        DS_WDATA = 3'b011,
        DS_RDATA = 3'b100,
        DS_ACK = 3'b101,
        DS_MACK = 3'b110
    } isc_dev_state_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_START = 2'b01,
        HS_BIT = 2'b10,
        HS_STOP = 2'b11
    } isc_host_state_t;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [1:0] sel_sy;
        logic [1:0] los_sy;
        isc_dev_state_t state;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rd;
        logic got_sub;
        logic nak;
        logic [2:0] ptr;
        logic [7:0] ref_mode;
        logic [7:0] action;
        logic [7:0] outcfg;
        logic sda_oe;
        logic acq_restart;
        logic sig_out;
        logic [4:0] rate_exp;
    } isc_dev_st_t;

    typedef struct packed {
        logic [1:0] sda_sy;
        isc_host_state_t state;
        logic [7:0] qcnt;
        logic [1:0] qph;
        logic [3:0] bitn;
        logic [2:0] stage;
        logic [7:0] sh;
        logic rw;
        logic [6:0] addr;
        logic [7:0] sub;
        logic [7:0] wdata;
        logic scl_oe;
        logic sda_oe;
        logic busy;
        logic done;
        logic nack;
        logic [7:0] rdata;
    } isc_host_st_t;

endpackage : isc_pkg

`default_nettype wire

// ---- isc_bus_if.sv ----
/*
 * The two open-drain wires between master and slave.
 * Assumes pull-ups: a wire is low only while some end drives it low.
 */
`timescale 1ns/1ns
`default_nettype none

interface isc_bus_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // wired-and resolution of the two lines
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input sda);
    modport dev (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : isc_bus_if

`default_nettype wire

// ---- isc_dev.sv ----
/*
 * Slave end of the two-wire control port: address match, subaddressed
 * register file with auto-increment, and the control outputs it steers.
 * Assumes the master drives the clock and never stretches; lines and the
 * loss detector level arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "isc_map.svh"

module isc_dev
    import isc_pkg::*;
(
    input wire logic clk, // 25 MHz system clock
    input wire logic arst_n, // asynchronous reset, active low
    isc_bus_if.dev bus, // two-wire bus, slave side
    input wire logic address_select_pin, // level of address bit 5
    input wire logic signal_lost_in, // raw loss detector, high = lost
    output logic signal_absent_output, // loss indication, polarity set
    output logic acq_restart, // one-cycle pulse: new acquisition
    output logic lock_to_ref_en, // lock to reference enabled
    output logic fine_meas_en, // fine rate measurement enabled
    output logic [1:0] ref_range, // expected reference range
    output logic [3:0] ratio, // data rate divide exponent
    output logic [4:0] rate_exp // signed ratio minus range, lock mode
);

    isc_dev_st_t q;
    isc_dev_st_t nxt;

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    // next state
    always_comb begin
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] rd_byte;
        logic [2:0] ptr_inc;
        logic [6:0] my_addr;
        scl = 1'b0;
        sda = 1'b0;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        rd_byte = 8'h00;
        ptr_inc = 3'h0;
        my_addr = 7'h00;
        nxt = q;
        nxt.acq_restart = 1'b0;

        // two-flop synchronisers; stage 2 of scl/sda keeps the previous level
        nxt.scl_sy = {q.scl_sy[1], q.scl_sy[0], bus.scl};
        nxt.sda_sy = {q.sda_sy[1], q.sda_sy[0], bus.sda};
        nxt.sel_sy = {q.sel_sy[0], address_select_pin};
        nxt.los_sy = {q.los_sy[0], signal_lost_in};

        scl = q.scl_sy[1];
        sda = q.sda_sy[1];
        scl_rise = scl & ~q.scl_sy[2];
        scl_fall = ~scl & q.scl_sy[2];
        start_c = scl & q.scl_sy[2] & q.sda_sy[2] & ~sda;
        stop_c = scl & q.scl_sy[2] & ~q.sda_sy[2] & sda;
        my_addr = {`ISC_ADDR_TOP, q.sel_sy[1], `ISC_ADDR_LOW5};
        ptr_inc = (q.ptr == `ISC_SUB_LAST) ? q.ptr : q.ptr + 3'h1;

        // read-back multiplexer
        case (q.ptr)
            `ISC_SUB_REFMODE: rd_byte = q.ref_mode;
            `ISC_SUB_ACTION: rd_byte = q.action;
            `ISC_SUB_OUTCFG: rd_byte = q.outcfg;
            `ISC_SUB_STATUS: rd_byte = {7'h00, q.los_sy[1]};
            default: rd_byte = 8'h00;
        endcase

        // protocol engine
        if (start_c) begin
            nxt.state = DS_ADDR;
            nxt.cnt = 4'h0;
            nxt.got_sub = 1'b0;
            nxt.sda_oe = 1'b0;
        end else if (stop_c) begin
            nxt.state = DS_IDLE;
            nxt.sda_oe = 1'b0;
        end else begin
            case (q.state)
                DS_IDLE: begin
                    nxt.sda_oe = 1'b0;
                end
                DS_ADDR, DS_SUB, DS_WDATA: begin
                    if (scl_rise && q.cnt != `ISC_BYTE_BITS) begin
                        nxt.sh = {q.sh[6:0], sda};
                        nxt.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == `ISC_BYTE_BITS) begin
                        nxt.cnt = 4'h0;
                        nxt.state = DS_ACK;
                        nxt.sda_oe = 1'b1;
                        if (q.state == DS_ADDR) begin
                            nxt.rd = q.sh[0];
                            if (q.sh[7:1] != my_addr) begin
                                nxt.state = DS_IDLE;
                                nxt.sda_oe = 1'b0;
                            end
                        end else if (q.state == DS_SUB) begin
                            if (q.sh < `ISC_SUB_LIMIT) begin
                                nxt.ptr = q.sh[2:0];
                                nxt.got_sub = 1'b1;
                            end else begin
                                nxt.state = DS_IDLE;
                                nxt.sda_oe = 1'b0;
                            end
                        end else begin
                            // register write, then advance the pointer
                            case (q.ptr)
                                `ISC_SUB_REFMODE: nxt.ref_mode = q.sh;
                                `ISC_SUB_ACTION: begin
                                    nxt.action = q.sh;
                                    nxt.acq_restart = q.action[`ISC_ACQ_BIT] & ~q.sh[`ISC_ACQ_BIT];
                                end
                                `ISC_SUB_OUTCFG: nxt.outcfg = q.sh;
                                default: nxt.sh = q.sh;
                            endcase
                            nxt.ptr = ptr_inc;
                        end
                    end
                end
                DS_ACK: begin
                    // hold the acknowledge through the ninth pulse
                    if (scl_fall) begin
                        nxt.sda_oe = 1'b0;
                        nxt.cnt = 4'h0;
                        if (q.rd) begin
                            nxt.state = DS_RDATA;
                            nxt.sh = rd_byte;
                            nxt.sda_oe = ~rd_byte[7];
                        end else if (q.got_sub) begin
                            nxt.state = DS_WDATA;
                        end else begin
                            nxt.state = DS_SUB;
                        end
                    end
                end
                DS_RDATA: begin
                    if (scl_rise) begin
                        nxt.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == `ISC_BYTE_BITS) begin
                            nxt.sda_oe = 1'b0;
                            nxt.state = DS_MACK;
                            nxt.ptr = ptr_inc;
                        end else begin
                            nxt.sh = {q.sh[6:0], 1'b0};
                            nxt.sda_oe = ~q.sh[6];
                        end
                    end
                end
                DS_MACK: begin
                    // master low on the ninth pulse asks for another byte
                    if (scl_rise) begin
                        nxt.nak = sda;
                    end else if (scl_fall) begin
                        nxt.cnt = 4'h0;
                        if (q.nak) begin
                            nxt.state = DS_IDLE;
                        end else begin
                            nxt.state = DS_RDATA;
                            nxt.sh = rd_byte;
                            nxt.sda_oe = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    nxt.state = DS_IDLE;
                    nxt.sda_oe = 1'b0;
                end
            endcase
        end

        // registered control outputs
        nxt.sig_out = q.los_sy[1] ^ q.outcfg[`ISC_LOSPOL_BIT];
        // target exponent: rate = ref * 2^(ratio - range)
        nxt.rate_exp = q.ref_mode[`ISC_REF_LOCK_BIT] ?
            5'({1'b0, q.ref_mode[`ISC_RATIO_MSB:`ISC_RATIO_LSB]}
               - {3'b000, q.ref_mode[`ISC_RANGE_MSB:`ISC_RANGE_LSB]}) : 5'h00;
    end

    // outputs straight from the state register
    assign bus.s_sda_o = 1'b0; // open drain: only ever pulls low
    assign bus.s_sda_oe = q.sda_oe;
    assign signal_absent_output = q.sig_out;
    assign acq_restart = q.acq_restart;
    assign lock_to_ref_en = q.ref_mode[`ISC_REF_LOCK_BIT];
    assign fine_meas_en = q.ref_mode[`ISC_REF_MEAS_BIT];
    assign ref_range = q.ref_mode[`ISC_RANGE_MSB:`ISC_RANGE_LSB];
    assign ratio = q.ref_mode[`ISC_RATIO_MSB:`ISC_RATIO_LSB];
    assign rate_exp = q.rate_exp;

endmodule : isc_dev

`default_nettype wire

// ---- isc_host.sv ----
/*
 * Master end of the two-wire control port: one-register write or read
 * (subaddress write, repeated start, one byte read with no acknowledge).
 * Assumes the slave never stretches the clock; sda is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "isc_map.svh"

module isc_host
    import isc_pkg::*;
(
    input wire logic clk, // 25 MHz system clock
    input wire logic arst_n, // asynchronous reset, active low
    isc_bus_if.host bus, // two-wire bus, master side
    input wire logic cmd_valid, // request, taken when not busy
    input wire logic cmd_read, // one = read register, zero = write
    input wire logic [6:0] cmd_dev_addr, // slave address
    input wire logic [7:0] cmd_sub, // register subaddress
    input wire logic [7:0] cmd_wdata, // write data
    output logic busy, // transfer in progress
    output logic done, // one-cycle pulse at end of transfer
    output logic nack, // slave refused a byte
    output logic [7:0] rdata // byte read back
);

    isc_host_st_t q;
    isc_host_st_t nxt;

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    // next state: each bus bit is four quarter periods
    always_comb begin
        logic tick;
        logic rx;
        tick = 1'b0;
        rx = 1'b0;
        nxt = q;
        nxt.done = 1'b0;
        nxt.sda_sy = {q.sda_sy[0], bus.sda};
        tick = q.busy && (q.qcnt == 8'(`ISC_QTR_CYCLES - 1));
        rx = (q.stage == 3'h4);
        if (q.busy) begin
            nxt.qcnt = tick ? 8'h00 : q.qcnt + 8'h01;
        end
        if (tick) begin
            nxt.qph = q.qph + 2'h1;
        end
        case (q.state)
            HS_IDLE: begin
                nxt.scl_oe = 1'b0;
                nxt.sda_oe = 1'b0;
                if (cmd_valid) begin
                    nxt.busy = 1'b1;
                    nxt.state = HS_START;
                    nxt.qcnt = 8'h00;
                    nxt.qph = 2'h0;
                    nxt.stage = 3'h0;
                    nxt.rw = cmd_read;
                    nxt.addr = cmd_dev_addr;
                    nxt.sub = cmd_sub;
                    nxt.wdata = cmd_wdata;
                    nxt.nack = 1'b0;
                end
            end
            HS_START: begin
                // sda falls while scl is high, one start per high period
                if (tick) begin
                    case (q.qph)
                        2'h0: nxt.sda_oe = 1'b0;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: nxt.sda_oe = 1'b1;
                        default: begin
                            nxt.scl_oe = 1'b1;
                            nxt.state = HS_BIT;
                            nxt.bitn = 4'h0;
                            nxt.sh = (q.stage == 3'h0) ? {q.addr, 1'b0} : {q.addr, 1'b1};
                        end
                    endcase
                end
            end
            HS_BIT: begin
                if (tick) begin
                    case (q.qph)
                        2'h0: nxt.sda_oe = (q.bitn != `ISC_BYTE_BITS && !rx) ? ~q.sh[7] : 1'b0;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (q.bitn != `ISC_BYTE_BITS) begin
                                nxt.sh = {q.sh[6:0], q.sda_sy[1]};
                            end else if (!rx) begin
                                nxt.nack = q.sda_sy[1];
                            end
                        end
                        default: begin
                            nxt.scl_oe = 1'b1;
                            nxt.bitn = q.bitn + 4'h1;
                            if (q.bitn == `ISC_BYTE_BITS) begin
                                nxt.bitn = 4'h0;
                                if (q.nack || q.stage == 3'h2 || rx) begin
                                    nxt.state = HS_STOP;
                                    nxt.rdata = rx ? q.sh : q.rdata;
                                end else if (q.stage == 3'h1 && q.rw) begin
                                    nxt.state = HS_START;
                                    nxt.stage = 3'h3;
                                end else begin
                                    nxt.stage = q.stage + 3'h1;
                                    nxt.sh = (q.stage == 3'h0) ? q.sub : q.wdata;
                                end
                            end
                        end
                    endcase
                end
            end
            HS_STOP: begin
                // sda rises while scl is high
                if (tick) begin
                    case (q.qph)
                        2'h0: nxt.sda_oe = 1'b1;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: nxt.sda_oe = 1'b0;
                        default: begin
                            nxt.state = HS_IDLE;
                            nxt.busy = 1'b0;
                            nxt.done = 1'b1;
                        end
                    endcase
                end
            end
            default: nxt.state = HS_IDLE;
        endcase
    end

    // outputs straight from the state register
    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe = q.scl_oe;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = q.sda_oe;
    assign busy = q.busy;
    assign done = q.done;
    assign nack = q.nack;
    assign rdata = q.rdata;

endmodule : isc_host

`default_nettype wire

// ---- isc_sva.sv ----
/* Checker for the two open-drain wires joining master and slave ends.
   Assumes it sits beside isc_bus_if and runs on the system clock. */
`timescale 1ns/1ns
`default_nettype none

module isc_sva (
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic m_scl_o, // master clock drive value
    input wire logic m_scl_oe, // master pulls clock low
    input wire logic m_sda_o, // master data drive value
    input wire logic m_sda_oe, // master pulls data low
    input wire logic s_sda_o, // slave data drive value
    input wire logic s_sda_oe, // slave pulls data low
    input wire logic scl, // resolved clock wire
    input wire logic sda // resolved data wire
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [11:0] hold_cnt_ff;
    logic [11:0] nxt_hold_cnt;

    // length of one unbroken slave drive on the data wire
    always_comb begin
        nxt_hold_cnt = s_sda_oe ? hold_cnt_ff + 12'h001 : 12'h000;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt_ff <= 12'h000;
        end else begin
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end

    a_start_then_low: assert property ($rose(m_sda_oe) && scl |-> ##[1:70] !scl)
        else $error("clock not lowered after start");
    a_start_slave_free: assert property ($rose(m_sda_oe) && scl |-> !s_sda_oe)
        else $error("slave drives data at a start");
    a_stop_idle: assert property ($fell(m_sda_oe) && scl |-> (sda && scl && !s_sda_oe) [*8])
        else $error("bus not idle after stop");
    a_slave_edge_low: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave changed data while clock high");
    a_ack_whole_high: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*8])
        else $error("slave drive dropped inside clock high");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high period too short");
    a_data_stable_high: assert property ($rose(scl) |-> $stable(sda) [*8])
        else $error("data wire moved just after clock rise");
    a_slave_release: assert property (hold_cnt_ff < 12'hA28)
        else $error("slave holds data low too long");
    a_open_drain: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
        else $error("a wire is driven high");
endmodule : isc_sva

`default_nettype wire

// ---- isc_bench.sv ----
/* Self-checking bench: master and slave ends joined by the bus interface.
   Assumes the design package, map header and interface are compiled first. */
`timescale 1ns/1ns
`default_nettype none

module isc_bench;
    logic clk, arst_n, sel, lost, cmd_valid, cmd_read, busy, done, nack;
    logic sig_abs, acq, lock_en, meas_en;
    logic [1:0] range;
    logic [3:0] ratio;
    logic [4:0] rate_exp;
    logic [6:0] cmd_dev_addr, dev;
    logic [7:0] cmd_sub, cmd_wdata, rdata, v;
    logic [7:0] regs [0:7];
    logic [31:0] seed;
    int compares, failures, cycles, pulses;

    isc_bus_if bus();
    isc_dev isc_dev_i (.clk(clk), .arst_n(arst_n), .bus(bus), .address_select_pin(sel),
        .signal_lost_in(lost), .signal_absent_output(sig_abs), .acq_restart(acq),
        .lock_to_ref_en(lock_en), .fine_meas_en(meas_en), .ref_range(range), .ratio(ratio),
        .rate_exp(rate_exp));
    isc_host isc_host_i (.clk(clk), .arst_n(arst_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr), .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata),
        .busy(busy), .done(done), .nack(nack), .rdata(rdata));
    isc_sva isc_sva_i (.clk(clk), .arst_n(arst_n), .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe),
        .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o),
        .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

    // clock, hang limit and restart pulse counting
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (acq === 1'b1) pulses++;
        if (cycles == 95000) begin
            failures++;
            final_report();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    // one transfer through the master, compared with the register model
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] s, input logic [7:0] w);
        int n;
        logic en;
        logic [7:0] ex;
        en = (a != dev) || (s >= 8'h08);
        ex = (s == 8'h03) ? {7'h00, lost} : ((s < 8'h03) ? regs[s[2:0]] : 8'h00);
        cmd_read = rd;
        cmd_dev_addr = a;
        cmd_sub = s;
        cmd_wdata = w;
        cmd_valid = 1'b1;
        @(posedge clk);
        #5 cmd_valid = 1'b0;
        check("busy", {7'h00, busy}, 8'h01);
        n = 0;
        while (done !== 1'b1 && n < 12000) begin
            @(posedge clk);
            #1 n++;
        end
        check("done", {7'h00, done}, 8'h01);
        @(posedge clk);
        #5 check("nack", {7'h00, nack}, {7'h00, en});
        check("busy", {7'h00, busy}, 8'h00);
        if (rd && !en) check("rdata", rdata, ex);
        if (!rd && !en && s < 8'h03) regs[s[2:0]] = w;
    endtask : xfer

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_dev_addr = 7'h00;
        cmd_sub = 8'h00;
        cmd_wdata = 8'h00;
        seed = xs(32'h0000E18A); // start value 57738
        sel = seed[3];
        lost = seed[9];
        for (int i = 0; i < 8; i++) regs[i] = 8'h00;
        dev = {1'b1, sel, 5'h00};
        repeat (12) @(posedge clk);
        #5 arst_n = 1'b1;
        repeat (4) @(posedge clk);
        #5 check("los", {7'h00, sig_abs}, {7'h00, lost});
        // lock mode then measure mode, never both enables together
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            v = {seed[7:6], 4'h5, k[0], ~k[0]};
            xfer(1'b0, dev, 8'h00, v);
            check("lock", {7'h00, lock_en}, {7'h00, ~k[0]});
            check("meas", {7'h00, meas_en}, {7'h00, k[0]});
            check("range", {6'h00, range}, {6'h00, v[7:6]});
            check("ratio", {4'h0, ratio}, 8'h05);
            check("rexp", {3'h0, rate_exp}, (k == 0) ? {3'h0, 5'h05 - {3'h0, v[7:6]}} : 8'h00);
        end
        xfer(1'b1, dev, 8'h00, 8'h00);
        xfer(1'b0, dev ^ 7'h20, 8'h01, 8'h20);
        xfer(1'b0, dev, 8'h08, 8'h00);
        xfer(1'b0, dev, 8'h02, 8'h04);
        lost = ~lost;
        repeat (5) @(posedge clk);
        #5 check("los", {7'h00, sig_abs}, {7'h00, ~lost});
        xfer(1'b1, dev, 8'h03, 8'h00);
        xfer(1'b0, dev, 8'h01, 8'h20);
        check("acq", pulses[7:0], 8'h00);
        xfer(1'b0, dev, 8'h01, 8'h00);
        check("acq", pulses[7:0], 8'h01);
        check("meas", {7'h00, meas_en}, 8'h01);
        xfer(1'b1, dev, 8'h07, 8'h00);
        final_report();
    end
endmodule : isc_bench

`default_nettype wire
